// File: hw/charge_bar_pkg.sv
// Constants shared by the charge bar display port.
package charge_bar_pkg;
  localparam int unsigned CLOCK_HZ = 25000000;
  localparam int unsigned DISPLAY_TIME_MS = 4000;
  localparam int unsigned DEBOUNCE_TIME_MS = 250;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned DISPLAY_CYCLES = CLOCK_HZ / 1000 * DISPLAY_TIME_MS;
  localparam int unsigned DEBOUNCE_CYCLES =
    CLOCK_HZ / 1000 * DEBOUNCE_TIME_MS;
  localparam int unsigned BLINK_CYCLES = CLOCK_HZ / 1000 * BLINK_HALF_MS;
  localparam int unsigned SEGMENTS = 5;
  localparam logic [7:0] STEP_FIVE = 8'h14;
  localparam logic [7:0] STEP_FOUR = 8'h19;
  localparam logic [7:0] FULL_PERCENT = 8'h64;
  localparam logic REQUEST_RESET_LEVEL = 1'b1;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHOW = 2'b10
  } display_state_t;
endpackage

// File: hw/charge_bar_display_port.sv
// Charge bar display port: debounced request, timed display, bar and blink.
//
// Function
// - Show four or five segments, picked by one configuration bit.
// - One configuration bit picks absolute or relative display mode.
// - Relative uses full charge capacity; absolute uses design capacity.
// - Relative mode scales by relative percent, 20% or 25% per segment.
// - Absolute mode scales by absolute percent with equal weighting.
// - Five segments: thresholds 20, 40, 60, 80 percent add segments.
// - Four segments: thresholds 25, 50, 75 percent add segments.
// - With four segments, fifth output shows capacity at least 100%.
// - Falling edge on request turns display on for four seconds.
// - Timer expiry turns display off even if request held low.
// - Redisplay needs return high then new fall after expiry.
// - Request level accepted only after 250 ms stable.
// - End-of-discharge flag keeps every segment off.
// - Segments stay off during charge counter calibration; display_active still follows the timer.
// - Display should be off before low-power storage entry.
// - Lit segments blink while remaining capacity below alarm level.
`timescale 1ns/100ps
module charge_bar_display_port
  import charge_bar_pkg::*;
#(
  parameter int unsigned DISPLAY_COUNT = charge_bar_pkg::DISPLAY_CYCLES,
  parameter int unsigned DEBOUNCE_COUNT = charge_bar_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned BLINK_COUNT = charge_bar_pkg::BLINK_CYCLES,
  parameter int unsigned CAP_WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic display_request_input,
  input wire logic segment_count_select,
  input wire logic display_reference_select,
  input wire logic [7:0] relative_charge_percent,
  input wire logic [7:0] absolute_charge_percent,
  input wire logic [CAP_WIDTH-1:0] remaining_capacity,
  input wire logic [CAP_WIDTH-1:0] capacity_alarm_level,
  input wire logic end_of_discharge_flag,
  input wire logic calibration_active,
  input wire logic storage_entry_pending,
  output logic [charge_bar_pkg::SEGMENTS-1:0] segment_out,
  output logic display_active
);
  import charge_bar_pkg::*;

  logic request_level;
  logic next_request_level;
  logic [31:0] stable_count;
  logic [31:0] next_stable_count;

  display_state_t state;
  display_state_t next_state;
  logic [31:0] show_count;
  logic [31:0] next_show_count;

  logic [31:0] blink_count;
  logic [31:0] next_blink_count;
  logic blink_phase;
  logic next_blink_phase;

  logic [SEGMENTS-1:0] next_segment_out;

  logic [7:0] percent;
  logic [SEGMENTS-1:0] bar;
  logic low_capacity;
  logic blank;
  logic fall_seen;

  // Turns a percent into the lit pattern for the chosen segment count.
  function automatic logic [SEGMENTS-1:0] bar_of(input logic [7:0] pct,
                                                 input logic four);
    logic [SEGMENTS-1:0] b;
    logic [7:0] step;
    b = '0;
    step = four ? STEP_FOUR : STEP_FIVE;
    b[0] = 1'b1;
    for (int i = 1; i < SEGMENTS; i++) begin
      if (!(four && i == SEGMENTS - 1)) begin
        b[i] = pct >= 8'(i * step);
      end
    end
    if (four) begin
      b[SEGMENTS-1] = pct >= FULL_PERCENT;
    end
    return b;
  endfunction

  // Debouncer: a new level is taken only after a full stable count.
  always_comb begin
    next_request_level = request_level;
    next_stable_count = 32'h0;
    // Any return to the taken level restarts the count from zero.
    if (display_request_input != request_level) begin
      next_stable_count = stable_count + 32'h1;
      if (stable_count + 32'h1 >= DEBOUNCE_COUNT) begin
        next_request_level = display_request_input;
        next_stable_count = 32'h0;
      end
    end
  end

  // Debouncer registers; the taken level starts high.
  always_ff @(posedge clock) begin
    if (rst) begin
      request_level <= REQUEST_RESET_LEVEL;
      stable_count <= 32'h0;
    end else begin
      request_level <= next_request_level;
      stable_count <= next_stable_count;
    end
  end

  // A fall is a taken change from high to low.
  assign fall_seen = request_level && !next_request_level;
  assign blank = end_of_discharge_flag || calibration_active ||
                 storage_entry_pending;

  // Display timer: idle until a taken fall, then a fixed period.
  always_comb begin
    next_state = state;
    next_show_count = show_count;
    case (state)
      ST_IDLE: begin
        // No display may start while storage entry is pending.
        if (fall_seen && !storage_entry_pending) begin
          next_state = ST_SHOW;
          next_show_count = 32'h0;
        end
      end
      ST_SHOW: begin
        // Falls while showing are ignored, not queued.
        next_show_count = show_count + 32'h1;
        if (show_count + 32'h1 >= DISPLAY_COUNT || storage_entry_pending) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Display timer registers.
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      show_count <= 32'h0;
    end else begin
      state <= next_state;
      show_count <= next_show_count;
    end
  end

  // Low capacity is remaining capacity below the alarm level.
  assign low_capacity = remaining_capacity < capacity_alarm_level;

  // Blink divider: the phase starts lit and toggles each half period.
  always_comb begin
    next_blink_count = 32'h0;
    next_blink_phase = 1'b1;
    // The phase only runs while a low-capacity display is showing.
    if (low_capacity && state == ST_SHOW) begin
      next_blink_phase = blink_phase;
      next_blink_count = blink_count + 32'h1;
      if (blink_count + 32'h1 >= BLINK_COUNT) begin
        next_blink_count = 32'h0;
        next_blink_phase = !blink_phase;
      end
    end
  end

  // Blink divider registers.
  always_ff @(posedge clock) begin
    if (rst) begin
      blink_count <= 32'h0;
      blink_phase <= 1'b1;
    end else begin
      blink_count <= next_blink_count;
      blink_phase <= next_blink_phase;
    end
  end

  // Relative percent is against full charge, absolute against design.
  assign percent = display_reference_select ? absolute_charge_percent
                                            : relative_charge_percent;
  assign bar = bar_of(percent, segment_count_select);

  // Segments follow the bar only while showing and not blanked.
  always_comb begin
    next_segment_out = '0;
    case (state)
      ST_SHOW: begin
        if (!blank && blink_phase) begin
          next_segment_out = bar;
        end
      end
      ST_IDLE: begin
        next_segment_out = '0;
      end
      default: begin
        next_segment_out = '0;
      end
    endcase
    if (end_of_discharge_flag || calibration_active) begin
      next_segment_out = '0;
    end
  end

  // Segment output register.
  always_ff @(posedge clock) begin
    if (rst) begin
      segment_out <= '0;
    end else begin
      segment_out <= next_segment_out;
    end
  end

  // The display period is the showing state.
  assign display_active = (state == ST_SHOW);
endmodule

// File: verif/charge_bar_sva.sv
// Port assertions for the charge bar display port.
`timescale 1ns/100ps
module charge_bar_sva #(parameter int unsigned DISPLAY_COUNT = 200,
  parameter int unsigned DEBOUNCE_COUNT = 10) (
  input wire logic clock, rst, display_request_input, segment_count_select,
  input wire logic display_reference_select, end_of_discharge_flag,
  input wire logic calibration_active, storage_entry_pending, display_active,
  input wire logic [7:0] relative_charge_percent, absolute_charge_percent,
  input wire logic [15:0] remaining_capacity, capacity_alarm_level,
  input wire logic [4:0] segment_out);
  logic [31:0] on_cnt, low_cnt;
  logic [4:0] bar;
  logic [7:0] pct;
  always_comb begin
    pct = display_reference_select ? absolute_charge_percent
      : relative_charge_percent;
    bar[0] = 1'b1;
    for (int i = 1; i < 5; i++) begin
      bar[i] = pct >= (segment_count_select ? 25 * i : 20 * i);
    end
  end
  always_ff @(posedge clock) begin
    on_cnt <= (rst || !display_active) ? 0 : on_cnt + 1;
    low_cnt <= (rst || display_request_input) ? 0 : low_cnt + 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_steady;
    remaining_capacity >= capacity_alarm_level ##1
    display_active && !end_of_discharge_flag && !calibration_active &&
      !storage_entry_pending && remaining_capacity >= capacity_alarm_level
      ##1 display_active;
  endsequence
  a_bar_value:
    assert property (s_steady |-> segment_out == $past(bar))
    else $error("bar pattern wrong");
  a_eod_dark: assert property (end_of_discharge_flag |=> !segment_out)
    else $error("segments lit at end of discharge");
  a_cal_dark: assert property (calibration_active |=> !segment_out)
    else $error("segments lit during calibration");
  a_store_off: assert property (storage_entry_pending |=> !display_active)
    else $error("display on before storage entry");
  a_idle_dark: assert property (!display_active |=> !segment_out)
    else $error("segments lit while idle");
  a_stand_long: assert property (display_active |-> on_cnt < DISPLAY_COUNT)
    else $error("display period too long");
  a_stand_full:
    assert property ($fell(display_active) && !$past(storage_entry_pending)
      |-> on_cnt == DISPLAY_COUNT) else $error("display period too short");
  a_debounce_low:
    assert property ($rose(display_active) |-> low_cnt >= DEBOUNCE_COUNT - 1)
    else $error("request accepted too soon");
  a_no_retrig: assert property ($fell(display_active) |-> !display_active [*8])
    else $error("display restarted without new request");
endmodule
bind charge_bar_display_port charge_bar_sva #(.DISPLAY_COUNT(DISPLAY_COUNT),
  .DEBOUNCE_COUNT(DEBOUNCE_COUNT)) sva (.*);

// File: verif/charge_bar_button.sv
// Pushbutton model driving the display request line.
`timescale 1ns/100ps
module charge_bar_button (
  input wire logic clock,
  output logic level
);
  initial level = 1'b1;
  // Each level is held for the whole count given by the bench.
  task automatic hold(input logic lv, input int n);
    @(posedge clock) level <= lv;
    repeat (n) @(posedge clock);
  endtask
endmodule

// File: verif/charge_bar_display_port_test.sv
// Self-checking bench for the charge bar display port.
`timescale 1ns/100ps
module charge_bar_display_port_test;
  logic clock = 0, rst = 1, display_request_input, segment_count_select = 0;
  logic display_reference_select = 0, end_of_discharge_flag = 0;
  logic calibration_active = 0, storage_entry_pending = 0, display_active;
  logic [7:0] relative_charge_percent = 0, absolute_charge_percent = 0;
  logic [15:0] remaining_capacity = 16'h0100, capacity_alarm_level = 16'h0010;
  logic [4:0] segment_out;
  logic [7:0] pc [9] = '{8'h13, 8'h14, 8'h4F, 8'h50, 8'h18, 8'h19, 8'h4B,
    8'h63, 8'h64};
  logic [4:0] ex [9] = '{5'h01, 5'h03, 5'h0F, 5'h1F, 5'h01, 5'h03, 5'h0F,
    5'h0F, 5'h1F};
  int err_count = 0, checks_done = 0, n;
  initial forever #20 clock = ~clock;
  charge_bar_button btn (.clock(clock), .level(display_request_input));
  charge_bar_display_port #(.DISPLAY_COUNT(200), .DEBOUNCE_COUNT(10),
    .BLINK_COUNT(20)) dut (.*);
  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    @(negedge clock);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
    @(posedge clock);
  endtask
  task automatic show(input logic [4:0] exp, input logic on);
    btn.hold(1'b0, 20);
    check({4'h0, display_active}, {4'h0, on});
    check(segment_out, exp);
    btn.hold(1'b1, 212);
    check({4'h0, display_active}, 5'h00);
    check(segment_out, 5'h00);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst <= 0;
    for (int i = 0; i < 9; i++) begin
      segment_count_select <= i > 3;
      display_reference_select <= i > 3;
      relative_charge_percent <= i > 3 ? 8'h00 : pc[i];
      absolute_charge_percent <= i > 3 ? pc[i] : 8'h00;
      show(ex[i], 1'b1);
    end
    $display("test bars done");
    btn.hold(1'b0, 230);
    check({4'h0, display_active}, 5'h00);
    btn.hold(1'b1, 12);
    $display("test held done");
    for (int k = 0; k < 3; k++) begin
      {storage_entry_pending, calibration_active, end_of_discharge_flag} <=
        3'b001 << k;
      show(5'h00, k < 2);
    end
    storage_entry_pending <= 0;
    $display("test blank done");
    remaining_capacity <= 16'h0001;
    btn.hold(1'b0, 14);
    n = 0;
    repeat (60) begin
      @(negedge clock);
      n += (segment_out === 5'h00);
    end
    check({4'h0, n > 10 && n < 50}, 5'h01);
    remaining_capacity <= 16'h0100;
    repeat (30) @(posedge clock);
    check(segment_out, 5'h1F);
    btn.hold(1'b1, 212);
    $display("test blink done");
    conclude();
  end
  initial begin
    #(40 * 20000);
    err_count++;
    conclude();
  end
endmodule
